// ---- psc_pkg.sv ----
package psc_pkg;
   // ----------------------------------------
   // word layout
   // ----------------------------------------
   localparam int DATA_W = 64;
   localparam int PAR_LO = 64;
   localparam int PAR_HI = 65;
   localparam int WORD_W = DATA_W + 2;
   localparam int STAMP_W = 25;
   localparam int PORT_W = 2;
   localparam int TAG_W = PORT_W + STAMP_W;
   // ----------------------------------------
   // ports and queues
   // ----------------------------------------
   localparam int NUM_PORTS = 3;
   localparam int NUM_QUEUES = 4;
   localparam int Q_POSTED = 0;
   localparam int Q_NONPOSTED = 1;
   localparam int Q_COMPL = 2;
   localparam int Q_INSERT = 3;
   localparam logic [1:0] UP_PORT = 2'h0;
   localparam logic [1:0] SINK_DEC = 2'h3;
   localparam int BUS_UP = 0;
   localparam int BUS_DN = 1;
   // ----------------------------------------
   // capacities
   // ----------------------------------------
   localparam int WORD_BYTES = 8;
   localparam int DWORD_BYTES = 4;
   localparam int PC_BYTES = 4096;
   localparam int NP_BYTES = 768;
   localparam int ORB_BYTES = 4096;
   localparam int DEC_BYTES = 2112;
   localparam int INS_DWORDS = 12;
   localparam int TLP_LIMIT = 32;
   localparam int INS_TLPS = 2;
   localparam int DEC_TLPS = 1;
   localparam int PC_WORDS = PC_BYTES / WORD_BYTES;
   localparam int NP_WORDS = NP_BYTES / WORD_BYTES;
   localparam int ORB_WORDS = ORB_BYTES / WORD_BYTES;
   localparam int DEC_WORDS = DEC_BYTES / WORD_BYTES;
   localparam int INS_WORDS = INS_DWORDS * DWORD_BYTES / WORD_BYTES;
   localparam int HDR_CREDITS = 32;
   localparam int PC_DATA_CREDITS = 208;
   localparam int NP_DATA_CREDITS = 32;
   localparam int INQ_SLACK = 1;
   typedef enum logic {PSC_IDLE, PSC_XFER} psc_bus_t;
endpackage : psc_pkg

// ---- psc_queue.sv ----
`timescale 1ns/1ps
module psc_queue #(
   parameter int WIDTH = 66,
   parameter int TAG_W = 27,
   parameter int WORDS = 512,
   parameter int TLPS = 32,
   parameter int SLACK = 0,
   parameter bit RETAIN = 1'b0
) (
   input logic mclk,
   input logic rst_n,
   input logic wr_valid,
   input logic [WIDTH-1:0] wr_data,
   input logic wr_last,
   input logic [TAG_W-1:0] wr_tag,
   output logic wr_ready,
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   output logic rd_last,
   output logic [TAG_W-1:0] rd_tag,
   input logic rd_pop,
   input logic release_tlp
);
   localparam int AW = (WORDS > 1) ? $clog2(WORDS) : 1;
   localparam int TW = (TLPS > 1) ? $clog2(TLPS) : 1;
   localparam int CW = $clog2(WORDS + 1);
   localparam int TCW = $clog2(TLPS + 1);

   // data queue and descriptor queue side by side
   logic [WIDTH:0] dmem [WORDS];
   logic [TAG_W+CW-1:0] tmem [TLPS];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [TW-1:0] twp, trp, tfp, next_twp, next_trp, next_tfp;
   logic [CW-1:0] used, len, next_used, next_len, rel_len;
   logic [TCW-1:0] tlps, unread, next_tlps, next_unread;
   logic fits, do_wr, do_pop, do_rel;

   function automatic logic [AW-1:0] wstep(input logic [AW-1:0] v);
      return (v == AW'(WORDS - 1)) ? '0 : v + 1'b1;
   endfunction : wstep

   function automatic logic [TW-1:0] tstep(input logic [TW-1:0] v);
      return (v == TW'(TLPS - 1)) ? '0 : v + 1'b1;
   endfunction : tstep

   // full on either words or descriptor count
   always_comb
   begin
      fits = (len != '0) || (tlps < TCW'(TLPS));
      wr_ready = (used + CW'(SLACK) < CW'(WORDS)) && fits;
      do_wr = wr_valid && (used < CW'(WORDS)) && fits;
      rd_valid = unread != '0;
      do_pop = rd_pop && rd_valid;
      // retained tlps free space only when the far end acknowledges
      do_rel = RETAIN ? (release_tlp && (tlps != unread)) : (do_pop && rd_last);
      rel_len = tmem[tfp][CW-1:0];
      next_wp = do_wr ? wstep(wp) : wp;
      next_rp = do_pop ? wstep(rp) : rp;
      next_len = !do_wr ? len : (wr_last ? '0 : len + 1'b1);
      next_twp = (do_wr && wr_last) ? tstep(twp) : twp;
      next_trp = (do_pop && rd_last) ? tstep(trp) : trp;
      next_tfp = do_rel ? tstep(tfp) : tfp;
      next_used = used + CW'(do_wr) - (do_rel ? rel_len : '0);
      next_tlps = tlps + TCW'(do_wr && wr_last) - TCW'(do_rel);
      next_unread = unread + TCW'(do_wr && wr_last) - TCW'(do_pop && rd_last);
   end

   assign rd_data = dmem[rp][WIDTH-1:0];
   assign rd_last = dmem[rp][WIDTH];
   assign rd_tag = tmem[trp][TAG_W+CW-1:CW];

   always_ff @(posedge mclk)
   begin
      if (do_wr)
         dmem[wp] <= {wr_last, wr_data};
      if (do_wr && wr_last)
         tmem[twp] <= {wr_tag, len + 1'b1};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp <= '0;
         rp <= '0;
         twp <= '0;
         trp <= '0;
         tfp <= '0;
         used <= '0;
         len <= '0;
         tlps <= '0;
         unread <= '0;
      end else
      begin
         wp <= next_wp;
         rp <= next_rp;
         twp <= next_twp;
         trp <= next_trp;
         tfp <= next_tfp;
         used <= next_used;
         len <= next_len;
         tlps <= next_tlps;
         unread <= next_unread;
      end
   end
endmodule : psc_queue

// ---- psc_skid.sv ----
`timescale 1ns/1ps
module psc_skid #(
   parameter int WIDTH = 67
) (
   input logic mclk,
   input logic rst_n,
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic hold_valid, next_hold_valid, next_out_valid, next_in_ready, take;
   logic [WIDTH-1:0] hold_data, next_hold_data, next_out_data;

   // second entry catches the word in flight when the receiver stalls
   always_comb
   begin
      take = in_valid && in_ready;
      next_out_valid = out_valid;
      next_out_data = out_data;
      next_hold_valid = hold_valid;
      next_hold_data = hold_data;
      if (!out_valid || out_ready)
      begin
         if (hold_valid)
         begin
            next_out_valid = 1'b1;
            next_out_data = hold_data;
            next_hold_valid = 1'b0;
         end else
         begin
            next_out_valid = take;
            next_out_data = in_data;
         end
      end else if (take)
      begin
         next_hold_valid = 1'b1;
         next_hold_data = in_data;
      end
      next_in_ready = !next_hold_valid;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         out_data <= '0;
         hold_valid <= 1'b0;
         hold_data <= '0;
         in_ready <= 1'b1;
      end else
      begin
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         hold_valid <= next_hold_valid;
         hold_data <= next_hold_data;
         in_ready <= next_in_ready;
      end
   end
endmodule : psc_skid

// ---- psc_core.sv ----
`timescale 1ns/1ps
// What this block does
// R1: port 0 upstream, ports 2 and 4 downstream
// R2: down bus from upstream, up bus to upstream
// R3: both buses move words in parallel
// R4: peer traffic via decoupler, up then down
// R5: per-port buffering, arbitration, scheduling, forwarding
// R6: four input queues per port
// R7: queue full on words or tlp count
// R8: posted/completion 4 KB, non-posted 768 B
// R9: output buffer retains tlps until acknowledged
// R10: output buffer 4 KB or 32 tlps
// R11: output buffer absorbs full-rate core writes
// R12: decoupler holds one 2112-byte tlp
// R13: insertion buffer 12 dwords, two tlps
// R14: 66-bit words, 64 data plus parity
// R15: dual stack: even cycle even port
// R16: narrow links leave their slots idle
// R17: single-port stack uses every cycle
// R18: demultiplex words into the port's queue
// R19: tlps move contiguously, never interleaved
// R20: egress written contiguously into output buffer
// R21: dual stack reads output buffers by slot
// R22: even parity per dword, carried unchanged
// R23: 25-bit timer stamps each queued tlp
module psc_core (
   input logic mclk,
   input logic rst_n,
   input logic a_valid,
   input logic [65:0] a_data,
   input logic a_last,
   input logic [1:0] a_queue,
   input logic [1:0] a_dest,
   input logic b_valid,
   input logic [65:0] b_data,
   input logic b_last,
   input logic [1:0] b_queue,
   input logic [1:0] b_dest,
   input logic b_dual,
   output logic [2:0] in_ready,
   output logic [2:0] par_err,
   output logic [2:0] out_valid,
   output logic [2:0][65:0] out_data,
   output logic [2:0] out_last,
   input logic [2:0] out_ready,
   input logic [2:0] out_ack
);
   localparam int NQ = psc_pkg::NUM_PORTS * psc_pkg::NUM_QUEUES;
   localparam int NSRC = NQ + 1;
   localparam int DEC = NQ;
   localparam int W = psc_pkg::WORD_W;
   localparam int TW = psc_pkg::TAG_W;
   localparam int SW = psc_pkg::STAMP_W;

   // ----------------------------------------
   // ingress demultiplex
   // ----------------------------------------
   logic phase, next_phase;
   logic [SW-1:0] stamp, next_stamp;
   logic [2:0] next_in_ready, next_par_err;
   logic [1:0] b_port;
   logic [2:0] iv, il;
   logic [2:0][W-1:0] id;
   logic [2:0][1:0] iq, idst;

   always_comb
   begin
      // single-port stack owns every cycle
      b_port = (b_dual && phase) ? 2'h2 : 2'h1; // R15
      iv = 3'h0;
      iv[0] = a_valid; // R16 R17
      iv[b_port] = b_valid; // R18
      id[0] = a_data;
      id[1] = b_data;
      id[2] = b_data;
      il = {b_last, b_last, a_last};
      iq = {b_queue, b_queue, a_queue};
      idst = {b_dest, b_dest, a_dest};
   end

   // ----------------------------------------
   // input frame buffers
   // ----------------------------------------
   logic [NSRC-1:0] hv, hl, pop;
   logic [NSRC-1:0][W-1:0] hd;
   logic [NSRC-1:0][TW-1:0] ht;
   logic [NQ-1:0] qr;
   logic [3:0] sv, sl, sr;
   logic [3:0][W-1:0] sd;
   logic [3:0][TW-1:0] st;

   // idle slots of a narrow link simply carry no valid
   for (genvar gp = 0; gp < psc_pkg::NUM_PORTS; gp++)
   begin : g_port
      for (genvar gk = 0; gk < psc_pkg::NUM_QUEUES; gk++)
      begin : g_q
         localparam int Q = gp * psc_pkg::NUM_QUEUES + gk;
         localparam int WORDS = (gk == psc_pkg::Q_NONPOSTED) ? psc_pkg::NP_WORDS :
            (gk == psc_pkg::Q_INSERT) ? psc_pkg::INS_WORDS : psc_pkg::PC_WORDS;
         localparam int TLPS = (gk == psc_pkg::Q_INSERT) ? psc_pkg::INS_TLPS :
            psc_pkg::TLP_LIMIT;
         psc_queue #(
            .WIDTH(W),
            .TAG_W(TW),
            .WORDS(WORDS), // R8 R13
            .TLPS(TLPS), // R7
            .SLACK(psc_pkg::INQ_SLACK),
            .RETAIN(1'b0)
         ) u_inq (
            .mclk(mclk),
            .rst_n(rst_n),
            .wr_valid(iv[gp] && (iq[gp] == 2'(gk))), // R6
            .wr_data(id[gp]),
            .wr_last(il[gp]),
            .wr_tag({idst[gp], stamp}), // R23
            .wr_ready(qr[Q]),
            .rd_valid(hv[Q]),
            .rd_data(hd[Q]),
            .rd_last(hl[Q]),
            .rd_tag(ht[Q]),
            .rd_pop(pop[Q]),
            .release_tlp(1'b0)
         );
      end
   end

   // ----------------------------------------
   // bus decoupler
   // ----------------------------------------
   psc_queue #(
      .WIDTH(W),
      .TAG_W(TW),
      .WORDS(psc_pkg::DEC_WORDS), // R12
      .TLPS(psc_pkg::DEC_TLPS),
      .SLACK(0),
      .RETAIN(1'b0)
   ) u_dec (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_valid(sv[3]),
      .wr_data(sd[3]),
      .wr_last(sl[3]),
      .wr_tag(st[3]),
      .wr_ready(sr[3]),
      .rd_valid(hv[DEC]),
      .rd_data(hd[DEC]),
      .rd_last(hl[DEC]),
      .rd_tag(ht[DEC]),
      .rd_pop(pop[DEC]),
      .release_tlp(1'b0)
   );

   // ----------------------------------------
   // bus scheduling
   // ----------------------------------------
   psc_pkg::psc_bus_t [1:0] bst, next_bst;
   logic [1:0][3:0] src, next_src, pick;
   logic [1:0][1:0] tgt, next_tgt, pick_tgt;
   logic [1:0][NSRC-1:0][1:0] qsink;
   logic [1:0][NSRC-1:0] elig;
   logic [1:0] move, found;

   // stamps wrap, so age is the sign of the difference
   function automatic logic older(input logic [SW-1:0] a, input logic [SW-1:0] b);
      logic [SW-1:0] d;
      d = a - b;
      return d[SW-1];
   endfunction : older

   always_comb
   begin
      int bs;
      bs = 0;
      elig = '0;
      qsink = '0;
      found = '0;
      pick = '0;
      pick_tgt = '0;
      pop = '0;
      for (int b = 0; b < 2; b++)
      begin
         for (int q = 0; q < NSRC; q++)
         begin
            if (b == psc_pkg::BUS_UP)
            begin
               // downstream sources only; non-upstream targets go peer
               qsink[b][q] = (ht[q][TW-1 -: 2] == psc_pkg::UP_PORT) ?
                  psc_pkg::UP_PORT : psc_pkg::SINK_DEC; // R2 R4
               elig[b][q] = (q >= psc_pkg::NUM_QUEUES) && (q < NQ) && hv[q] &&
                  sr[qsink[b][q]]; // R1
            end else
            begin
               qsink[b][q] = ht[q][TW-1 -: 2];
               elig[b][q] = ((q < psc_pkg::NUM_QUEUES) || (q == DEC)) && hv[q] &&
                  (qsink[b][q] != psc_pkg::UP_PORT) && sr[qsink[b][q]]; // R1 R2 R4
            end
            if (elig[b][q] && (!found[b] ||
               older(ht[q][SW-1:0], ht[pick[b]][SW-1:0]))) // R5 R23
            begin
               pick[b] = 4'(q);
               pick_tgt[b] = qsink[b][q];
               found[b] = 1'b1;
            end
         end
         // each bus advances on its own, both may move in one cycle
         move[b] = (bst[b] == psc_pkg::PSC_XFER) && hv[src[b]] && sr[tgt[b]]; // R3
         next_bst[b] = bst[b];
         next_src[b] = src[b];
         next_tgt[b] = tgt[b];
         // grant holds until the last word: no interleave on a bus
         unique case (bst[b])
            psc_pkg::PSC_IDLE:
               if (found[b])
               begin
                  next_bst[b] = psc_pkg::PSC_XFER;
                  next_src[b] = pick[b];
                  next_tgt[b] = pick_tgt[b];
               end
            psc_pkg::PSC_XFER:
               if (move[b] && hl[src[b]])
                  next_bst[b] = psc_pkg::PSC_IDLE; // R19
         endcase
         if (move[b])
            pop[src[b]] = 1'b1;
      end
      for (int s = 0; s < 4; s++)
      begin
         bs = (s == 1 || s == 2) ? psc_pkg::BUS_DN : psc_pkg::BUS_UP;
         sv[s] = move[bs] && (tgt[bs] == 2'(s)); // R20
         sd[s] = hd[src[bs]]; // R22
         sl[s] = hl[src[bs]];
         st[s] = ht[src[bs]];
      end
   end

   // ----------------------------------------
   // output and replay buffers
   // ----------------------------------------
   logic [2:0] ov, ol, opop, sk_ready, slot;
   logic [2:0][W-1:0] od;

   for (genvar gp = 0; gp < psc_pkg::NUM_PORTS; gp++)
   begin : g_out
      // space of an unacknowledged tlp is only freed by out_ack
      psc_queue #(
         .WIDTH(W),
         .TAG_W(TW),
         .WORDS(psc_pkg::ORB_WORDS), // R10 R11
         .TLPS(psc_pkg::TLP_LIMIT),
         .SLACK(0),
         .RETAIN(1'b1)
      ) u_orb (
         .mclk(mclk),
         .rst_n(rst_n),
         .wr_valid(sv[gp]),
         .wr_data(sd[gp]),
         .wr_last(sl[gp]),
         .wr_tag(st[gp]),
         .wr_ready(sr[gp]),
         .rd_valid(ov[gp]),
         .rd_data(od[gp]),
         .rd_last(ol[gp]),
         .rd_tag(),
         .rd_pop(opop[gp]),
         .release_tlp(out_ack[gp]) // R9
      );
      // dual stack: port 2 reads on even cycles, port 4 on odd
      assign slot[gp] = (gp == 0) || !b_dual || (phase == (gp == 2)); // R21
      assign opop[gp] = ov[gp] && sk_ready[gp] && slot[gp];
      psc_skid #(
         .WIDTH(W + 1)
      ) u_skid (
         .mclk(mclk),
         .rst_n(rst_n),
         .in_valid(opop[gp]),
         .in_ready(sk_ready[gp]),
         .in_data({ol[gp], od[gp]}),
         .out_valid(out_valid[gp]),
         .out_ready(out_ready[gp]),
         .out_data({out_last[gp], out_data[gp]})
      );
   end

   // ----------------------------------------
   // ready, parity and timer
   // ----------------------------------------
   always_comb
   begin
      next_phase = !phase;
      next_stamp = stamp + 1'b1; // R23
      for (int p = 0; p < psc_pkg::NUM_PORTS; p++)
      begin
         // registered ready, so the queues keep one word of slack
         next_in_ready[p] = &qr[p * psc_pkg::NUM_QUEUES +: psc_pkg::NUM_QUEUES]; // R7
         next_par_err[p] = par_err[p] | (iv[p] &&
            ((^{id[p][31:0], id[p][psc_pkg::PAR_LO]}) |
            (^{id[p][63:32], id[p][psc_pkg::PAR_HI]}))); // R14 R22
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase <= 1'b0;
         stamp <= '0;
         in_ready <= 3'h0;
         par_err <= 3'h0;
         bst <= '{psc_pkg::PSC_IDLE, psc_pkg::PSC_IDLE};
         src <= '0;
         tgt <= '0;
      end else
      begin
         phase <= next_phase;
         stamp <= next_stamp;
         in_ready <= next_in_ready;
         par_err <= next_par_err;
         bst <= next_bst;
         src <= next_src;
         tgt <= next_tgt;
      end
   end
endmodule : psc_core

// ---- psc_core_monitor.sv ----
`timescale 1ns/1ps
module psc_core_monitor (
   input logic mclk,
   input logic rst_n,
   input logic a_valid,
   input logic [65:0] a_data,
   input logic a_last,
   input logic [1:0] a_dest,
   input logic b_valid,
   input logic [1:0] b_dest,
   input logic [2:0] in_ready,
   input logic [2:0] par_err,
   input logic [2:0] out_valid,
   input logic [2:0][65:0] out_data,
   input logic [2:0] out_last,
   input logic [2:0] out_ready,
   input logic [2:0] out_ack
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ----
   // helper state
   // ----
   logic [1:0] cyc;
   logic seen_up;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cyc <= 2'h0;
         seen_up <= 1'b0;
      end
      else
      begin
         cyc <= (cyc == 2'h3) ? cyc : cyc + 2'h1;
         seen_up <= seen_up | (b_valid && b_dest == psc_pkg::UP_PORT);
      end
   end
   sequence s_up_tlp;
      a_valid && in_ready[0] && !a_last && a_dest == 2'h1 ##1 a_valid && a_last && a_dest == 2'h1;
   endsequence
   // ----
   // per-port egress
   // ----
   for (genvar i = 0; i < 3; i++)
   begin : g_port
      logic [5:0] outst;
      always_ff @(posedge mclk or negedge rst_n)
      begin
         if (!rst_n)
            outst <= 6'h00;
         else
            outst <= outst + 6'(out_valid[i] && out_ready[i] && out_last[i])
               - 6'(out_ack[i] && outst != 6'h00);
      end
      sequence s_stall;
         out_valid[i] && !out_ready[i];
      endsequence
      a_stall_hold: assert property (s_stall |=> out_valid[i] && $stable(out_data[i]))
         else $error("egress word changed while stalled");
      a_replay_cap: assert property (outst <= 6'(psc_pkg::TLP_LIMIT))
         else $error("more unacknowledged tlps than the output buffer holds");
      a_egress_par: assert property (out_valid[i] |-> !(^{out_data[i][64], out_data[i][31:0]})
         && !(^{out_data[i][65], out_data[i][63:32]}))
         else $error("egress word parity not even");
   end
   a_ready_boot: assert property (cyc == 2'h1 |-> in_ready == 3'h7)
      else $error("input buffers not ready after reset");
   a_par_sticky: assert property (!(|($past(par_err) & ~par_err)))
      else $error("parity error flag cleared without reset");
   a_par_detect: assert property (a_valid && in_ready[0] && (^{a_data[64], a_data[31:0]})
      |-> ##[1:2] par_err[0])
      else $error("bad parity word not flagged");
   a_down_route: assert property (s_up_tlp |-> ##[1:80] out_valid[1])
      else $error("upstream tlp not delivered to downstream port");
   a_up_source: assert property (out_valid[0] |-> seen_up)
      else $error("upstream port output without downstream source");
endmodule : psc_core_monitor
bind psc_core psc_core_monitor u_mon (.mclk, .rst_n, .a_valid, .a_data, .a_last, .a_dest,
   .b_valid, .b_dest, .in_ready, .par_err, .out_valid, .out_data, .out_last, .out_ready, .out_ack);

// ---- psc_link_sink.sv ----
`timescale 1ns/1ps
module psc_link_sink (
   input logic mclk,
   input logic rst_n,
   input logic [2:0] out_valid,
   input logic [2:0] out_last,
   input logic [2:0] ack_en,
   output logic [2:0] out_ready,
   output logic [2:0] out_ack
);
   logic [15:0] rnd;
   logic [5:0] pend [3];
   // stalls come from a free pattern so the skid buffer sees bursts of both kinds
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rnd <= 16'hACE1;
         out_ready <= 3'h0;
         out_ack <= 3'h0;
         pend <= '{6'h00, 6'h00, 6'h00};
      end
      else
      begin
         rnd <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
         for (int i = 0; i < 3; i++)
         begin
            out_ready[i] <= rnd[i] | rnd[i + 5];
            // acks only what arrived, one pulse at a time
            out_ack[i] <= ack_en[i] && pend[i] != 6'h00 && rnd[i + 8] && !out_ack[i];
            pend[i] <= pend[i] + 6'(out_valid[i] && out_ready[i] && out_last[i])
               - 6'(ack_en[i] && pend[i] != 6'h00 && rnd[i + 8] && !out_ack[i]);
         end
      end
   end
endmodule : psc_link_sink

// ---- psc_core_tb.sv ----
`timescale 1ns/1ps
module psc_core_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic a_valid = 1'b0, a_last = 1'b0, b_valid = 1'b0, b_last = 1'b0, b_dual = 1'b0;
   logic [65:0] a_data = '0, b_data = '0;
   logic [1:0] a_queue = 2'h0, a_dest = 2'h0, b_queue = 2'h0, b_dest = 2'h0;
   logic [2:0] in_ready, par_err, out_valid, out_last, out_ready, out_ack;
   logic [2:0][65:0] out_data;
   logic [2:0] ack_en = 3'h7;
   logic [66:0] exp_q [3][$];
   logic [31:0] seed = 32'h7DA4;
   int error_cnt = 0, checks = 0, edge_n = 0, base;
   int rx_tlps [3] = '{0, 0, 0};
   always #12.5 mclk = ~mclk;
   psc_core dut (.mclk, .rst_n, .a_valid, .a_data, .a_last, .a_queue, .a_dest, .b_valid,
      .b_data, .b_last, .b_queue, .b_dest, .b_dual, .in_ready, .par_err, .out_valid,
      .out_data, .out_last, .out_ready, .out_ack);
   psc_link_sink u_sink (.mclk, .rst_n, .out_valid, .out_last, .ack_en, .out_ready, .out_ack);
   always @(posedge mclk or negedge rst_n)
      edge_n <= rst_n ? edge_n + 1 : 0;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string name, input logic [66:0] exp, input logic [66:0] seen);
      checks++;
      if (exp !== seen)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // ----
   // ingress driver: valid drops while waiting, so no word is taken twice
   // ----
   task automatic send(input int src, input logic [1:0] dest, input logic [1:0] q,
      input int n, input bit bad);
      logic [65:0] w;
      bit ok;
      for (int k = 0; k < n; k++)
      begin
         seed = lfsr(seed);
         w[63:0] = {seed, seed ^ 32'h5A5A5A5A};
         w[64] = ^w[31:0] ^ bad;
         w[65] = ^w[63:32];
         ok = 1'b0;
         while (!ok)
         begin
            @(posedge mclk);
            ok = in_ready[src] === 1'b1 && (src == 0 || !b_dual || edge_n[0] == (src == 1));
            if (src == 0)
            begin
               {a_valid, a_data, a_last, a_queue, a_dest} <= {ok, w, k == n - 1, q, dest};
            end
            else
            begin
               {b_valid, b_data, b_last, b_queue, b_dest} <= {ok, w, k == n - 1, q, dest};
            end
         end
         if (!bad)
            exp_q[dest].push_back({k == n - 1, w});
      end
      @(posedge mclk);
      if (src == 0)
         a_valid <= 1'b0;
      else
         b_valid <= 1'b0;
   endtask : send
   task automatic drain(input string name);
      int n;
      n = 0;
      while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() != 0 && n < 4000)
      begin
         @(posedge mclk);
         n++;
      end
      chk({name, " drained"}, 67'h0, 67'(exp_q[0].size() + exp_q[1].size() + exp_q[2].size()));
      $display("test %s done", name);
   endtask : drain
   // ----
   // egress watcher
   // ----
   always @(posedge mclk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (rst_n && out_valid[i] === 1'b1 && out_ready[i] === 1'b1)
         begin
            rx_tlps[i] += int'(out_last[i]);
            if (exp_q[i].size() == 0)
               chk("unexpected egress word", 67'h0, {out_last[i], out_data[i]});
            else
               chk("egress word", exp_q[i].pop_front(), {out_last[i], out_data[i]});
         end
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   initial
   begin
      #1500000;
      error_cnt++;
      $display("BAD watchdog expected finish seen hang");
      final_report();
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("in_ready", 67'h7, 67'(in_ready));
      for (int q = 0; q < 4; q++)
         for (int d = 1; d < 3; d++)
            send(0, 2'(d), 2'(q), 2, 1'b0);
      drain("downstream");
      fork
         send(0, 2'h1, 2'(psc_pkg::Q_POSTED), 6, 1'b0);
         send(1, psc_pkg::UP_PORT, 2'(psc_pkg::Q_COMPL), 6, 1'b0);
      join
      drain("parallel buses");
      send(1, 2'h2, 2'(psc_pkg::Q_POSTED), psc_pkg::DEC_WORDS, 1'b0);
      drain("peer max tlp");
      @(posedge mclk);
      b_dual <= 1'b1;
      send(2, psc_pkg::UP_PORT, 2'(psc_pkg::Q_NONPOSTED), 4, 1'b0);
      send(2, 2'h1, 2'(psc_pkg::Q_COMPL), 3, 1'b0);
      drain("dual stack");
      b_dual <= 1'b0;
      ack_en <= 3'h3;
      base = rx_tlps[2];
      for (int k = 0; k < psc_pkg::TLP_LIMIT + 2; k++)
         send(0, 2'h2, 2'(psc_pkg::Q_POSTED), 1, 1'b0);
      repeat (300) @(posedge mclk);
      chk("tlps held unacked", 67'(psc_pkg::TLP_LIMIT), 67'(rx_tlps[2] - base));
      ack_en <= 3'h7;
      drain("replay limit");
      send(0, psc_pkg::UP_PORT, 2'(psc_pkg::Q_INSERT), 1, 1'b1);
      repeat (3) @(posedge mclk);
      chk("par_err", 67'h1, 67'(par_err));
      $display("test parity done");
      final_report();
   end
endmodule : psc_core_tb
